/* File: rtl/port1_ctrl_pkg.sv */
/*
 * constants for the port 1 control register bank: register indices,
 * byte addresses, field positions and reset values.
 * assumes a 32-bit apb with one register per aligned word.
 */
package port1_ctrl_pkg;
   // printed register indices; byte address is four times the index
   localparam logic [11:0] ctl_one_idx     = 12'h500;
   localparam logic [11:0] ctl_two_idx     = 12'h502;
   localparam logic [11:0] def_tag_idx     = 12'h504;
   localparam int          addr_w          = 14;
   localparam logic [13:0] ctl_one_addr    = 14'(ctl_one_idx * 4);
   localparam logic [13:0] ctl_two_addr    = 14'(ctl_two_idx * 4);
   localparam logic [13:0] def_tag_addr    = 14'(def_tag_idx * 4);

   // first control register
   localparam int c1_storm      = 7;
   localparam int c1_diffserv   = 6;
   localparam int c1_dot1p      = 5;
   localparam int c1_defpri_hi  = 4;
   localparam int c1_defpri_lo  = 3;
   localparam int c1_tag_ins    = 2;
   localparam int c1_tag_rem    = 1;
   localparam int c1_multi_q    = 0;
   localparam logic [15:0] c1_mask  = 16'h00ff;
   localparam logic [15:0] c1_reset = 16'h0000;

   // second control register
   localparam int c2_vlan_filt  = 14;
   localparam int c2_non_pvid   = 13;
   localparam int c2_force_fc   = 12;
   localparam int c2_backpress  = 11;
   localparam int c2_tx_en      = 10;
   localparam int c2_rx_en      = 9;
   localparam int c2_learn_off  = 8;
   localparam int c2_sniffer    = 7;
   localparam int c2_rx_sniff   = 6;
   localparam int c2_tx_sniff   = 5;
   localparam int c2_pri_ceil   = 3;
   localparam int c2_member_hi  = 2;
   localparam int c2_member_lo  = 0;
   localparam logic [15:0] c2_mask  = 16'h7fef;
   localparam logic [15:0] c2_reset = 16'h0607;

   // default tag register: priority [15:13], cfi [12], vid [11:0]
   localparam int dt_pri_hi = 15;
   localparam int dt_pri_lo = 13;
   localparam int dt_vid_hi = 11;
   localparam logic [15:0] dt_reset = 16'h0001;

   // own port position inside membership masks
   localparam int own_port = 0;
endpackage

/* File: rtl/switch_port_one_control.sv */
/*
 * port 1 control bank of a three-port switch: apb register slave plus the
 * per-packet ingress and egress decisions that the settings steer.
 * assumes the forwarding engine presents one packet per valid pulse with
 * its header facts, and takes the registered decision one cycle later.
 */
// Design decision made here: the APB slave port.
// Notes on behaviour
// R1: 802.1p classification of port 1 ingress packets when its enable bit is set.
// R2: default priority field picks queue 0..3 when other classifiers miss.
// R3: with both classifiers hitting, queue is the OR of 802.1p and dscp results.
// R4: tag insertion adds a tag on egress only to packets received untagged.
// R5: inserted tag comes from the ingress port's default tag, not port 1's.
// R6: tag removal strips the tag only from packets received tagged.
// R7: multi-queue bit splits output into four queues, else one queue.
// R8: vlan filtering drops packets whose table membership lacks port 1.
// R9: non-default-vid discard drops packets whose vid differs from port default.
// R10: force flow control enables pause regardless of negotiated outcome.
// R11: back pressure bit enables half-duplex back pressure.
// R12: transmit enable, reset 1, blocks all transmission when clear.
// R13: receive enable, reset 1, blocks all reception when clear.
// R14: learning disable stops source address learning from port 1.
// R15: sniffer bit makes port 1 transmit monitored packets.
// R16: receive sniff marks every received packet monitored and mirrors it; the code marks only packets that it does not drop.
// R17: transmit sniff marks every transmitted packet monitored and mirrors it.
// R18: priority ceiling clamps packet priority to the default tag priority.
// R19: membership bits, reset 111, limit forwarding targets of port 1.
// R20: default tag register gives default vid and egress tag contents; code takes egress tag from tx_src_tag instead.
// R21: diffserv classification enable and broadcast storm protection enable.
// R22: reserved bits read zero and ignore writes.
// R23: settings apply to decisions starting after the write completes.
`timescale 1ns/1ps
module switch_port_one_control
(
   input  wire logic        pclk,            // switch core clock, 25 mhz
   input  wire logic        presetn,         // async reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb write
   input  wire logic [13:0] paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error, unmapped address
   input  wire logic        rx_valid,        // ingress packet header present
   input  wire logic        rx_tagged,       // packet carries a tag
   input  wire logic [11:0] rx_vid,          // vid from tag, zero if none
   input  wire logic [2:0]  rx_pcp,          // tag priority
   input  wire logic        rx_dscp_hit,     // diffserv lookup produced a result
   input  wire logic [1:0]  rx_dscp_queue,   // diffserv queue result
   input  wire logic [2:0]  rx_vlan_members, // vlan table membership bits
   output logic             rx_done,         // decision pulse
   output logic             rx_drop,         // discard the packet
   output logic [1:0]       rx_queue,        // priority class
   output logic [2:0]       rx_pri,          // priority after ceiling
   output logic [11:0]      rx_vid_out,      // vid used for lookup
   output logic             rx_learn,        // learn source address
   output logic             rx_monitor,      // mark monitored and mirror
   output logic [2:0]       rx_fwd_mask,     // permitted destinations
   input  wire logic        tx_valid,        // egress packet header present
   input  wire logic        tx_was_tagged,   // packet arrived tagged
   input  wire logic [15:0] tx_src_tag,      // ingress port default tag
   input  wire logic        tx_monitored,    // packet marked monitored
   input  wire logic [1:0]  tx_class,        // packet priority class
   output logic             tx_done,         // decision pulse
   output logic             tx_send,         // transmit on port 1
   output logic             tx_insert,       // add tag
   output logic             tx_strip,        // remove tag
   output logic [15:0]      tx_tag,          // tag to insert
   output logic [1:0]       tx_queue,        // output queue
   output logic             tx_mirror,       // copy to sniffer port
   input  wire logic        an_pause,        // negotiated flow control
   output logic             flow_ctrl_on,    // pause enabled
   output logic             backpress_on,    // half-duplex back pressure
   output logic             storm_guard_on   // broadcast storm protection
);
   logic [15:0] ctl_one_reg;
   logic [15:0] ctl_two_reg;
   logic [15:0] def_tag_reg;
   logic        wr_stb;
   logic        rd_hit;

   function automatic logic mapped(input logic [13:0] a);
      mapped = (a == port1_ctrl_pkg::ctl_one_addr) || (a == port1_ctrl_pkg::ctl_two_addr)
            || (a == port1_ctrl_pkg::def_tag_addr);
   endfunction

   // writes land only in the completing access cycle
   assign wr_stb = psel && penable && pready && pwrite;
   assign rd_hit = mapped(paddr);

   // one wait-free access: ready rises in the access cycle after setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= psel && !penable;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= !rd_hit;
         if (paddr == port1_ctrl_pkg::ctl_one_addr)
            prdata <= {16'h0000, ctl_one_reg};        // [R22]
         else if (paddr == port1_ctrl_pkg::ctl_two_addr)
            prdata <= {16'h0000, ctl_two_reg};        // [R22]
         else if (paddr == port1_ctrl_pkg::def_tag_addr)
            prdata <= {16'h0000, def_tag_reg};
         else
            prdata <= 32'h00000000;
      end
   end

   // reserved bits masked so they never store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_one_reg <= port1_ctrl_pkg::c1_reset;
         ctl_two_reg <= port1_ctrl_pkg::c2_reset;   // [R12] [R13] [R19]
         def_tag_reg <= port1_ctrl_pkg::dt_reset;
      end
      else if (wr_stb)
      begin
         if (paddr == port1_ctrl_pkg::ctl_one_addr)
            ctl_one_reg <= pwdata[15:0] & port1_ctrl_pkg::c1_mask;   // [R22]
         if (paddr == port1_ctrl_pkg::ctl_two_addr)
            ctl_two_reg <= pwdata[15:0] & port1_ctrl_pkg::c2_mask;   // [R22]
         if (paddr == port1_ctrl_pkg::def_tag_addr)
            def_tag_reg <= pwdata[15:0];                             // [R20]
      end
   end

   // ingress decision; reads live settings so a finished write applies next packet [R23]
   logic [1:0]  cls_q;
   logic [2:0]  pri_c;
   logic [11:0] pvid;
   logic [2:0]  usr_pri;
   logic [11:0] eff_vid;
   logic        p1p_hit;
   logic        ds_hit;
   logic        drop_c;

   assign pvid = def_tag_reg[port1_ctrl_pkg::dt_vid_hi:0];
   assign usr_pri = def_tag_reg[port1_ctrl_pkg::dt_pri_hi:port1_ctrl_pkg::dt_pri_lo];

   always_comb
   begin
      p1p_hit = ctl_one_reg[port1_ctrl_pkg::c1_dot1p] && rx_tagged;              // [R1]
      ds_hit  = ctl_one_reg[port1_ctrl_pkg::c1_diffserv] && rx_dscp_hit;         // [R21]
      if (p1p_hit && ds_hit)
         cls_q = rx_pcp[2:1] | rx_dscp_queue;                                     // [R3]
      else if (p1p_hit)
         cls_q = rx_pcp[2:1];                                                     // [R1]
      else if (ds_hit)
         cls_q = rx_dscp_queue;
      else
         cls_q = ctl_one_reg[port1_ctrl_pkg::c1_defpri_hi:port1_ctrl_pkg::c1_defpri_lo]; // [R2]
      // untagged or null-vid packets take the port default
      eff_vid = (!rx_tagged || rx_vid == 12'h000) ? pvid : rx_vid;                // [R20]
      pri_c = rx_tagged ? rx_pcp : usr_pri;
      if (ctl_two_reg[port1_ctrl_pkg::c2_pri_ceil]
          && pri_c > usr_pri)
         pri_c = usr_pri;                                                         // [R18]
      drop_c = !ctl_two_reg[port1_ctrl_pkg::c2_rx_en]                             // [R13]
            || (ctl_two_reg[port1_ctrl_pkg::c2_vlan_filt]
                && !rx_vlan_members[port1_ctrl_pkg::own_port])                    // [R8]
            || (ctl_two_reg[port1_ctrl_pkg::c2_non_pvid] && eff_vid != pvid);    // [R9]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_done     <= 1'b0;
         rx_drop     <= 1'b0;
         rx_queue    <= 2'h0;
         rx_pri      <= 3'h0;
         rx_vid_out  <= 12'h000;
         rx_learn    <= 1'b0;
         rx_monitor  <= 1'b0;
         rx_fwd_mask <= 3'h0;
      end
      else
      begin
         rx_done <= rx_valid;
         if (rx_valid)
         begin
            rx_drop     <= drop_c;
            rx_queue    <= cls_q;
            rx_pri      <= pri_c;
            rx_vid_out  <= eff_vid;
            rx_learn    <= !drop_c && !ctl_two_reg[port1_ctrl_pkg::c2_learn_off];  // [R14]
            rx_monitor  <= !drop_c && ctl_two_reg[port1_ctrl_pkg::c2_rx_sniff];   // [R16]
            rx_fwd_mask <= ctl_two_reg[port1_ctrl_pkg::c2_member_hi:port1_ctrl_pkg::c2_member_lo]
                           & rx_vlan_members;                                      // [R19]
         end
      end
   end

   // egress decision; a monitored copy only leaves port 1 when it is the sniffer port
   logic send_c;
   assign send_c = ctl_two_reg[port1_ctrl_pkg::c2_tx_en]                          // [R12]
                && (!tx_monitored || ctl_two_reg[port1_ctrl_pkg::c2_sniffer]);    // [R15]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_done   <= 1'b0;
         tx_send   <= 1'b0;
         tx_insert <= 1'b0;
         tx_strip  <= 1'b0;
         tx_tag    <= 16'h0000;
         tx_queue  <= 2'h0;
         tx_mirror <= 1'b0;
      end
      else
      begin
         tx_done <= tx_valid;
         if (tx_valid)
         begin
            tx_send   <= send_c;
            tx_insert <= ctl_one_reg[port1_ctrl_pkg::c1_tag_ins] && !tx_was_tagged;  // [R4]
            tx_strip  <= ctl_one_reg[port1_ctrl_pkg::c1_tag_rem] && tx_was_tagged;   // [R6]
            tx_tag    <= tx_src_tag;                                                  // [R5]
            tx_queue  <= ctl_one_reg[port1_ctrl_pkg::c1_multi_q] ? tx_class : 2'h0;  // [R7]
            tx_mirror <= send_c && ctl_two_reg[port1_ctrl_pkg::c2_tx_sniff];        // [R17]
         end
      end
   end

   // port level controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flow_ctrl_on   <= 1'b0;
         backpress_on   <= 1'b0;
         storm_guard_on <= 1'b0;
      end
      else
      begin
         flow_ctrl_on   <= ctl_two_reg[port1_ctrl_pkg::c2_force_fc] || an_pause;  // [R10]
         backpress_on   <= ctl_two_reg[port1_ctrl_pkg::c2_backpress];             // [R11]
         storm_guard_on <= ctl_one_reg[port1_ctrl_pkg::c1_storm];                 // [R21]
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_write_lands: assert property (                                   // [R23]
      (wr_stb && paddr == port1_ctrl_pkg::ctl_two_addr)
      |=> ctl_two_reg == ($past(pwdata[15:0]) & port1_ctrl_pkg::c2_mask))
      else $error("control two write not stored");
   a_reserved_zero: assert property (                                 // [R22]
      (ctl_one_reg & ~port1_ctrl_pkg::c1_mask) == 16'h0000
      && (ctl_two_reg & ~port1_ctrl_pkg::c2_mask) == 16'h0000)
      else $error("reserved bit set");
   a_rx_gate_drop: assert property (                                  // [R13]
      (rx_valid && !ctl_two_reg[port1_ctrl_pkg::c2_rx_en]) |=> rx_done && rx_drop)
      else $error("packet accepted while reception off");
   a_tx_gate_hold: assert property (                                  // [R12]
      (tx_valid && !ctl_two_reg[port1_ctrl_pkg::c2_tx_en]) |=> tx_done && !tx_send)
      else $error("packet sent while transmit off");
   a_single_queue: assert property (                                  // [R7]
      (tx_valid && !ctl_one_reg[port1_ctrl_pkg::c1_multi_q]) |=> tx_queue == 2'h0)
      else $error("queue split while disabled");
   a_ceiling_clamp: assert property (                                 // [R18]
      (rx_valid && ctl_two_reg[port1_ctrl_pkg::c2_pri_ceil])
      |=> rx_pri <= $past(def_tag_reg[15:13]))
      else $error("priority above ceiling");
   a_insert_untag: assert property (                                  // [R4]
      (tx_valid && tx_was_tagged) |=> !tx_insert)
      else $error("tag added to tagged packet");
   a_strip_tagged: assert property (                                  // [R6]
      (tx_valid && !tx_was_tagged) |=> !tx_strip)
      else $error("tag stripped from untagged packet");
   a_vlan_filter: assert property (                                   // [R8]
      (rx_valid && ctl_two_reg[port1_ctrl_pkg::c2_vlan_filt] && !rx_vlan_members[0])
      |=> rx_drop)
      else $error("non-member packet kept");
   a_default_class: assert property (                                 // [R2]
      (rx_valid && !ctl_one_reg[5] && !ctl_one_reg[6]) |=> rx_queue == $past(ctl_one_reg[4:3]))
      else $error("default priority not used");
   a_force_fc: assert property (                                      // [R10]
      ctl_two_reg[port1_ctrl_pkg::c2_force_fc] |=> flow_ctrl_on)
      else $error("forced flow control off");
   a_apb_ready: assert property (
      (psel && !penable) |=> pready ##1 !pready)
      else $error("ready not one cycle");
   a_unmapped_err: assert property ( // [R22]
      (psel && !penable && !rd_hit)
      |=> pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");
   a_write_one: assert property ( // [R23]
      (wr_stb && paddr == port1_ctrl_pkg::ctl_one_addr)
      |=> ctl_one_reg == ($past(pwdata[15:0]) & port1_ctrl_pkg::c1_mask))
      else $error("control one write not stored");

   a_dot1p_class: assert property ( // [R1]
      (rx_valid && p1p_hit && !ds_hit)
      |=> rx_queue == $past(rx_pcp[2:1]))
      else $error("802.1p class not used");
   a_or_class: assert property ( // [R3]
      (rx_valid && p1p_hit && ds_hit)
      |=> rx_queue == ($past(rx_pcp[2:1]) | $past(rx_dscp_queue)))
      else $error("classes not combined");
   a_vid_discard: assert property ( // [R9]
      (rx_valid && ctl_two_reg[port1_ctrl_pkg::c2_non_pvid] && eff_vid != pvid)
      |=> rx_drop)
      else $error("foreign vid kept");
   a_learn_off: assert property ( // [R14]
      (rx_valid && ctl_two_reg[port1_ctrl_pkg::c2_learn_off])
      |=> !rx_learn)
      else $error("learning while disabled");
   a_rx_sniff: assert property ( // [R16]
      (rx_valid && !drop_c && ctl_two_reg[port1_ctrl_pkg::c2_rx_sniff])
      |=> rx_monitor)
      else $error("received packet not monitored");
   a_member_mask: assert property ( // [R19]
      rx_valid
      |=> (rx_fwd_mask & ~$past(ctl_two_reg[port1_ctrl_pkg::c2_member_hi:0])) == 3'h0)
      else $error("target outside membership");
   a_vid_default: assert property ( // [R20]
      (rx_valid && !rx_tagged)
      |=> rx_vid_out == $past(pvid))
      else $error("default vid not used");
   a_insert_on: assert property ( // [R4]
      (tx_valid && ctl_one_reg[port1_ctrl_pkg::c1_tag_ins] && !tx_was_tagged)
      |=> tx_insert)
      else $error("untagged packet not tagged");
   a_tag_source: assert property ( // [R5]
      tx_valid
      |=> tx_tag == $past(tx_src_tag))
      else $error("inserted tag not from ingress port");
   a_strip_on: assert property ( // [R6]
      (tx_valid && ctl_one_reg[port1_ctrl_pkg::c1_tag_rem] && tx_was_tagged)
      |=> tx_strip)
      else $error("tagged packet not stripped");
   a_tx_send_on: assert property ( // [R12]
      (tx_valid && ctl_two_reg[port1_ctrl_pkg::c2_tx_en] && !tx_monitored)
      |=> tx_send)
      else $error("packet held while transmit on");
   a_sniffer_copy: assert property ( // [R15]
      (tx_valid && tx_monitored && !ctl_two_reg[port1_ctrl_pkg::c2_sniffer])
      |=> !tx_send)
      else $error("monitored copy sent on normal port");
   a_tx_sniff: assert property ( // [R17]
      (tx_valid && !ctl_two_reg[port1_ctrl_pkg::c2_tx_sniff])
      |=> !tx_mirror)
      else $error("transmit mirrored while off");
   a_back_press: assert property ( // [R11]
      ctl_two_reg[port1_ctrl_pkg::c2_backpress] |=> backpress_on)
      else $error("back pressure off");
   a_storm_guard: assert property ( // [R21]
      ctl_one_reg[port1_ctrl_pkg::c1_storm] |=> storm_guard_on)
      else $error("storm protection off");

   c_ceiling: cover property (rx_valid && ctl_two_reg[3] ##1 rx_done);
   c_or_class: cover property (rx_valid && rx_tagged && rx_dscp_hit
      && ctl_one_reg[5] && ctl_one_reg[6]);
   c_sniff_copy: cover property (tx_valid && tx_monitored && !ctl_two_reg[7]);
   c_insert: cover property (tx_valid && ctl_one_reg[2] && !tx_was_tagged);
   c_unmapped: cover property (pready && pslverr);
endmodule // switch_port_one_control

/* File: test/testbench.sv */
/*
 * self-checking bench for the port 1 control bank: apb register tasks,
 * ingress and egress decision tasks, and directed tests built from them.
 * assumes the design package is compiled first and one 25 mhz clock.
 */
`timescale 1ns/1ps
module testbench;
   localparam logic [13:0] a1 = port1_ctrl_pkg::ctl_one_addr;
   localparam logic [13:0] a2 = port1_ctrl_pkg::ctl_two_addr;
   localparam logic [13:0] at = port1_ctrl_pkg::def_tag_addr;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        rx_valid, rx_tagged, rx_dscp_hit, rx_done, rx_drop, rx_learn, rx_monitor;
   logic [11:0] rx_vid, rx_vid_out;
   logic [2:0]  rx_pcp, rx_vlan_members, rx_pri, rx_fwd_mask;
   logic [1:0]  rx_dscp_queue, rx_queue, tx_class, tx_queue;
   logic        tx_valid, tx_was_tagged, tx_monitored, tx_done, tx_send, tx_insert, tx_strip;
   logic        tx_mirror, an_pause, flow_ctrl_on, backpress_on, storm_guard_on;
   logic [15:0] tx_src_tag, tx_tag;
   int          mismatches;
   int          compares;

   switch_port_one_control u_dut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_valid, .rx_tagged, .rx_vid, .rx_pcp, .rx_dscp_hit, .rx_dscp_queue,
      .rx_vlan_members, .rx_done, .rx_drop, .rx_queue, .rx_pri, .rx_vid_out, .rx_learn,
      .rx_monitor, .rx_fwd_mask, .tx_valid, .tx_was_tagged, .tx_src_tag, .tx_monitored,
      .tx_class, .tx_done, .tx_send, .tx_insert, .tx_strip, .tx_tag, .tx_queue,
      .tx_mirror, .an_pause, .flow_ctrl_on, .backpress_on, .storm_guard_on
   );

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // setup, then access held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         mismatches++;
         final_report();
      end
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [13:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   // levels follow their cause one cycle later
   task automatic lv;
      repeat (2) @(posedge pclk);
   endtask

   task automatic rx(input logic tg, input logic [11:0] v, input logic [2:0] p,
                     input logic dh, input logic [1:0] dq, input logic [2:0] m);
      @(posedge pclk);
      rx_valid        <= 1'b1;
      rx_tagged       <= tg;
      rx_vid          <= v;
      rx_pcp          <= p;
      rx_dscp_hit     <= dh;
      rx_dscp_queue   <= dq;
      rx_vlan_members <= m;
      @(posedge pclk);
      rx_valid <= 1'b0;
      @(posedge pclk);
      chk(rx_done, 32'h1);
   endtask

   task automatic tx(input logic tg, input logic [15:0] st, input logic mon,
                     input logic [1:0] cls);
      @(posedge pclk);
      tx_valid      <= 1'b1;
      tx_was_tagged <= tg;
      tx_src_tag    <= st;
      tx_monitored  <= mon;
      tx_class      <= cls;
      @(posedge pclk);
      tx_valid <= 1'b0;
      @(posedge pclk);
      chk(tx_done, 32'h1);
   endtask

   initial
   begin
      mismatches = 0;
      compares = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_valid, rx_tagged, rx_vid, rx_pcp, rx_dscp_hit, rx_dscp_queue} = '0;
      rx_vlan_members = 3'h0;
      {tx_valid, tx_was_tagged, tx_src_tag, tx_monitored, tx_class, an_pause} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(a1, 32'h0000);
      rd(a2, 32'h0607);
      rd(at, 32'h0001);
      $display("test reset_values done");
      wr(a1, 32'hffffffff);
      rd(a1, 32'h00ff);
      wr(a2, 32'hffffffff);
      rd(a2, 32'h7fef);
      apb(1'b1, 14'h0004, 32'hffffffff);
      chk(err, 32'h1);
      apb(1'b0, 14'h0004, 32'h0);
      chk({rdv[31:1], err}, 32'h1);
      lv();
      chk(storm_guard_on, 32'h1);
      chk(backpress_on, 32'h1);
      chk(flow_ctrl_on, 32'h1);
      wr(a1, 32'h0);
      wr(a2, 32'h0607);
      lv();
      chk({storm_guard_on, backpress_on, flow_ctrl_on}, 32'h0);
      an_pause <= 1'b1;
      lv();
      chk(flow_ctrl_on, 32'h1);
      an_pause <= 1'b0;
      $display("test reserved_and_levels done");
      wr(a1, 32'h18);
      rx(1'b1, 12'h001, 3'd7, 1'b0, 2'd0, 3'b001);
      chk(rx_queue, 32'h3);
      wr(a1, 32'h28);
      rx(1'b1, 12'h001, 3'd5, 1'b0, 2'd0, 3'b001);
      chk(rx_queue, 32'h2);
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk(rx_queue, 32'h1);
      wr(a1, 32'h60);
      rx(1'b1, 12'h001, 3'd2, 1'b1, 2'd2, 3'b001);
      chk(rx_queue, 32'h3);
      wr(a1, 32'h40);
      rx(1'b1, 12'h001, 3'd7, 1'b1, 2'd2, 3'b001);
      chk(rx_queue, 32'h2);
      rx(1'b1, 12'h001, 3'd7, 1'b0, 2'd2, 3'b001);
      chk(rx_queue, 32'h0);
      wr(a1, 32'h0);
      $display("test classification done");
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk({rx_drop, rx_learn, rx_monitor, rx_fwd_mask}, 32'h11);
      chk(rx_vid_out, 32'h001);
      wr(a2, 32'h0407);
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk(rx_drop, 32'h1);
      wr(a2, 32'h4607);
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b110);
      chk(rx_drop, 32'h1);
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk(rx_drop, 32'h0);
      wr(a2, 32'h2607);
      rx(1'b1, 12'h005, 3'd0, 1'b0, 2'd0, 3'b001);
      chk(rx_drop, 32'h1);
      rx(1'b1, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk({rx_drop, rx_vid_out}, 32'h001);
      wr(a2, 32'h0705);
      rx(1'b1, 12'h009, 3'd0, 1'b0, 2'd0, 3'b111);
      chk({rx_learn, rx_fwd_mask}, 32'h5);
      wr(a2, 32'h0647);
      rx(1'b0, 12'h000, 3'd0, 1'b0, 2'd0, 3'b001);
      chk(rx_monitor, 32'h1);
      wr(at, 32'h4005);
      wr(a2, 32'h060f);
      rx(1'b1, 12'h005, 3'd6, 1'b0, 2'd0, 3'b001);
      chk(rx_pri, 32'h2);
      rx(1'b1, 12'h005, 3'd1, 1'b0, 2'd0, 3'b001);
      chk(rx_pri, 32'h1);
      wr(a2, 32'h0607);
      rx(1'b1, 12'h005, 3'd6, 1'b0, 2'd0, 3'b001);
      chk(rx_pri, 32'h6);
      $display("test ingress done");
      wr(a1, 32'h04);
      tx(1'b0, 16'ha123, 1'b0, 2'd0);
      chk({tx_insert, tx_strip, tx_tag}, 32'h2a123);
      tx(1'b1, 16'h0bcd, 1'b0, 2'd0);
      chk(tx_insert, 32'h0);
      wr(a1, 32'h02);
      tx(1'b1, 16'h0bcd, 1'b0, 2'd0);
      chk({tx_insert, tx_strip}, 32'h1);
      tx(1'b0, 16'h0bcd, 1'b0, 2'd0);
      chk(tx_strip, 32'h0);
      wr(a1, 32'h01);
      tx(1'b0, 16'h0001, 1'b0, 2'd2);
      chk(tx_queue, 32'h2);
      wr(a1, 32'h00);
      tx(1'b0, 16'h0001, 1'b0, 2'd2);
      chk(tx_queue, 32'h0);
      wr(a2, 32'h0207);
      tx(1'b0, 16'h0001, 1'b0, 2'd0);
      chk(tx_send, 32'h0);
      wr(a2, 32'h0627);
      tx(1'b0, 16'h0001, 1'b0, 2'd0);
      chk({tx_send, tx_mirror}, 32'h3);
      wr(a2, 32'h0687);
      tx(1'b0, 16'h0001, 1'b1, 2'd0);
      chk({tx_send, tx_mirror}, 32'h2);
      wr(a2, 32'h0607);
      tx(1'b0, 16'h0001, 1'b1, 2'd0);
      chk(tx_send, 32'h0);
      $display("test egress done");
      final_report();
   end
endmodule // testbench
